// [inc/ips_pkg.sv]
// Constants and types for the image parameter sequencer
// Function
// [RL1] Preview flag makes the selected entry's settings visible live; clear it before running.
// [RL2] Entry step source picks which event advances the pointer.
// [RL3] Source 0x80: advance at every exposure start, new set for next image.
// [RL4] 0x82 rising input edge, 0x84 high level advance; applied at next exposure.
// [RL5] Undefined step source codes behave as 0x80.
// [RL6] Step source is stored per entry, chosen by the entry index field.
// [RL7] Each entry is used for n consecutive images before advancing.
// [RL8] Hold count 0 acts as hold count 1.
// [RL9] Software stepping uses 0x82 or 0x84 with no input configured to step.
// [RL10] Each manual advance write steps once, honouring the hold count.
// [RL11] Manual restart returns the pointer to the first entry.
// [RL12] Up to two step inputs, ANDed; an input may be a reset input instead.
// [RL13] Level stepping increments every image while the step input is high.
// [RL14] Each rising step edge gives exactly one immediate increment.
// [RL15] Input reset is rising-edge only and returns pointer to first entry.
// [RL16] Input stepping and input reset can also be issued by software.
// [RL17] Past the sequence length the last entry's settings stay in effect.
// [RL18] Cancelling sequence mode invalidates storage; software reloads before reuse.
// [RL19] Multi-shot or stream start command resets the pointer.
// [RL20] Every single-shot acquisition restarts from the first entry.
// [RL21] Software sets auto wrap only before starting the sequence.
// [RL22] With deferred transport, software captures no more images than the length.
// [RL23] Parameters held in a store of 32 complete sets.
// [RL24] Software can read back the current pointer.
// [RL25] At each exposure the parameters load from the entry at the pointer.
package ips_pkg;
  localparam int unsigned DEPTH = 32;
  localparam int unsigned PTR_W = 5;
  localparam int unsigned ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_PARAM = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_DATA = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_STEP = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_IOCFG = 8'h10;
  // CTRL fields
  localparam int unsigned CTL_EN = 0;
  localparam int unsigned CTL_PREVIEW = 1;
  localparam int unsigned CTL_WRAP = 2;
  localparam int unsigned CTL_LOADED = 3;
  localparam int unsigned CTL_LEN_LSB = 8;
  // STEP fields
  localparam int unsigned STP_ADV = 0;
  localparam int unsigned STP_RST = 1;
  localparam int unsigned STP_IO_STEP = 2;
  localparam int unsigned STP_IO_RST = 3;
  localparam int unsigned STP_PTR_LSB = 8;
  // PARAM fields
  localparam int unsigned PRM_IDX_LSB = 0;
  localparam int unsigned PRM_SRC_LSB = 8;
  localparam int unsigned PRM_HOLD_LSB = 16;
  // Step source codes
  localparam logic [7:0] SRC_EXPO = 8'h80;
  localparam logic [7:0] SRC_EDGE = 8'h82;
  localparam logic [7:0] SRC_LEVEL = 8'h84;
  // Reset values
  localparam logic [7:0] RST_HOLD = 8'h01;
  localparam logic [7:0] RST_LEN = 8'h20;
  // Input line roles
  localparam logic [1:0] LINE_OFF = 2'h0;
  localparam logic [1:0] LINE_STEP = 2'h1;
  localparam logic [1:0] LINE_RESET = 2'h2;

  typedef struct packed {
    logic expo_start;
    logic multi_shot;
    logic stream_start;
    logic single_shot;
  } ips_acq_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } ips_bus_t;
endpackage : ips_pkg

// [design/ips_sequencer.sv]
// Image parameter sequencer: entry store, pointer stepping, register port
`timescale 1ns/1ps
`default_nettype none
module ips_sequencer
  import ips_pkg::*;
#(
  parameter int unsigned PARAM_W = 16
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // Register port
  input wire ips_bus_t bus_i,
  output logic [31:0] rdata_o,
  // Acquisition events
  input wire ips_acq_t acq_i,
  // External input lines
  input wire logic [1:0] in_line_i,
  // Applied settings and status
  output logic [PARAM_W-1:0] param_o,
  output logic [PTR_W-1:0] cur_ptr_o,
  output logic preview_o
);

  // Entry store, one set per entry
  logic [PARAM_W-1:0] mem_param [DEPTH];
  logic [7:0] mem_src [DEPTH];
  logic [7:0] mem_hold [DEPTH];

  logic enable_r;
  logic preview_r;
  logic wrap_r;
  logic loaded_r;
  logic [7:0] len_r;
  logic [7:0] sel_r;
  logic [3:0] iocfg_r;
  logic [PTR_W-1:0] ptr_r;
  logic [7:0] rep_r;
  logic step_lvl_d_r;
  logic rst_lvl_d_r;

  logic wr_ctrl, wr_param, wr_data, wr_step;
  logic man_adv, man_rst, soft_io_step, soft_io_rst;
  logic step_lvl, rst_lvl, step_rise, rst_rise;
  logic [7:0] cur_src, hold_eff;
  logic mode_edge, mode_level, mode_expo;
  logic step_req, advance, restart, at_last;
  logic [PTR_W-1:0] last_idx, sel_idx;
  logic [7:0] ptr_ext;

  assign wr_ctrl = bus_i.wr && bus_i.addr == OFS_CTRL;
  assign wr_param = bus_i.wr && bus_i.addr == OFS_PARAM;
  assign wr_data = bus_i.wr && bus_i.addr == OFS_DATA;
  assign wr_step = bus_i.wr && bus_i.addr == OFS_STEP;
  assign man_adv = wr_step && bus_i.wdata[STP_ADV];
  assign man_rst = wr_step && bus_i.wdata[STP_RST];
  assign soft_io_step = wr_step && bus_i.wdata[STP_IO_STEP]; // RL16
  assign soft_io_rst = wr_step && bus_i.wdata[STP_IO_RST]; // RL16
  assign sel_idx = sel_r[PTR_W-1:0];
  assign ptr_ext = {{(8-PTR_W){1'b0}}, ptr_r};

  // Step lines AND together; with none configured the level stays low
  always_comb begin
    logic any_step;
    logic all_step;
    logic any_rst;
    any_step = 1'b0;
    all_step = 1'b1;
    any_rst = 1'b0;
    for (int i = 0; i < 2; i++) begin
      if (iocfg_r[2*i +: 2] == LINE_STEP) begin
        any_step = 1'b1; // RL12
        all_step = all_step & in_line_i[i]; // RL12
      end
      if (iocfg_r[2*i +: 2] == LINE_RESET) begin
        any_rst = any_rst | in_line_i[i]; // RL12
      end
    end
    step_lvl = any_step & all_step;
    rst_lvl = any_rst;
  end

  assign step_rise = step_lvl & ~step_lvl_d_r; // RL14
  assign rst_rise = rst_lvl & ~rst_lvl_d_r; // RL15

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      step_lvl_d_r <= 1'b0;
      rst_lvl_d_r <= 1'b0;
    end else begin
      step_lvl_d_r <= step_lvl;
      rst_lvl_d_r <= rst_lvl;
    end
  end

  // Source of the entry in use decides the stepping event
  assign cur_src = mem_src[ptr_r]; // RL6
  assign mode_edge = cur_src == SRC_EDGE; // RL2
  assign mode_level = cur_src == SRC_LEVEL; // RL2
  assign mode_expo = !mode_edge && !mode_level; // RL5
  assign hold_eff = (mem_hold[ptr_r] == 8'h00) ? 8'h01 : mem_hold[ptr_r]; // RL8

  assign step_req = enable_r && !preview_r && (
    (mode_expo && acq_i.expo_start) || // RL3
    (mode_edge && (step_rise || soft_io_step)) || // RL4 RL14
    (mode_level && acq_i.expo_start && step_lvl) || // RL13
    (mode_level && soft_io_step) ||
    man_adv); // RL10
  assign advance = step_req && (rep_r + 8'h01 >= hold_eff); // RL7 RL10

  assign restart = man_rst || rst_rise || soft_io_rst || // RL11 RL15
    acq_i.multi_shot || acq_i.stream_start || // RL19
    acq_i.single_shot; // RL20

  // Clamp the length to the store depth
  always_comb begin
    if (len_r == 8'h00) begin
      last_idx = '0;
    end else if (len_r >= 8'(DEPTH)) begin
      last_idx = PTR_W'(DEPTH - 1);
    end else begin
      last_idx = PTR_W'(len_r - 8'h01);
    end
  end
  assign at_last = ptr_r == last_idx;

  always_ff @(posedge mclk_i) begin
    if (reset_i || !enable_r || restart) begin
      ptr_r <= '0;
    end else if (advance && !at_last) begin
      ptr_r <= ptr_r + PTR_W'(1); // RL3 RL4
    end else if (advance && wrap_r) begin
      ptr_r <= '0;
    end
    // Otherwise the last entry stays in use  RL17
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i || !enable_r || restart || advance) begin
      rep_r <= 8'h00;
    end else if (step_req) begin
      rep_r <= rep_r + 8'h01; // RL7
    end
  end

  // Control registers
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      enable_r <= 1'b0;
      preview_r <= 1'b0;
      wrap_r <= 1'b0;
      len_r <= RST_LEN;
      iocfg_r <= {LINE_OFF, LINE_OFF};
    end else begin
      if (wr_ctrl) begin
        enable_r <= bus_i.wdata[CTL_EN];
        preview_r <= bus_i.wdata[CTL_PREVIEW]; // RL1
        wrap_r <= bus_i.wdata[CTL_WRAP];
        len_r <= bus_i.wdata[CTL_LEN_LSB +: 8];
      end
      if (bus_i.wr && bus_i.addr == OFS_IOCFG) begin
        iocfg_r <= bus_i.wdata[3:0];
      end
    end
  end

  // Storage is reusable by others once sequencing stops
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      loaded_r <= 1'b0;
    end else if (wr_param || wr_data) begin
      loaded_r <= 1'b1;
    end else if (wr_ctrl && !bus_i.wdata[CTL_EN] && enable_r) begin
      loaded_r <= 1'b0; // RL18
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      sel_r <= 8'h00;
    end else if (wr_param) begin
      sel_r <= bus_i.wdata[PRM_IDX_LSB +: 8];
    end
  end

  // Entry fields written to the entry named in the same word
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_src[i] <= SRC_EXPO;
        mem_hold[i] <= RST_HOLD;
      end
    end else if (wr_param) begin
      mem_src[bus_i.wdata[PRM_IDX_LSB +: PTR_W]] <=
        bus_i.wdata[PRM_SRC_LSB +: 8]; // RL6
      mem_hold[bus_i.wdata[PRM_IDX_LSB +: PTR_W]] <=
        bus_i.wdata[PRM_HOLD_LSB +: 8];
    end
  end

  // No reset on the payload: a plain memory, invalid until reloaded
  always_ff @(posedge mclk_i) begin
    if (wr_data) begin
      mem_param[sel_idx] <= bus_i.wdata[PARAM_W-1:0]; // RL23
    end
  end

  // Applied settings: live view of selected entry, else latched per image
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      param_o <= '0;
    end else if (enable_r && preview_r) begin
      param_o <= mem_param[sel_idx]; // RL1
    end else if (enable_r && acq_i.expo_start) begin
      param_o <= mem_param[ptr_r]; // RL25
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      preview_o <= 1'b0;
      cur_ptr_o <= '0;
    end else begin
      preview_o <= enable_r && preview_r;
      cur_ptr_o <= ptr_r;
    end
  end

  // Read data in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      rdata_o <= 32'h0000_0000;
    end else if (bus_i.rd) begin
      unique case (bus_i.addr)
        OFS_CTRL: rdata_o <= {16'h0000, len_r, 4'h0, loaded_r, wrap_r,
                              preview_r, enable_r};
        OFS_PARAM: rdata_o <= {8'h00, mem_hold[sel_idx], mem_src[sel_idx],
                               sel_r};
        OFS_DATA: rdata_o <= 32'(mem_param[sel_idx]);
        OFS_STEP: rdata_o <= {16'h0000, ptr_ext, 8'h00}; // RL24
        OFS_IOCFG: rdata_o <= {28'h000_0000, iocfg_r};
        default: rdata_o <= 32'h0000_0000;
      endcase
    end else begin
      rdata_o <= 32'h0000_0000;
    end
  end

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (reset_i);

  property p_restart;
    restart |=> ptr_r == '0;
  endproperty
  a_restart: assert property (p_restart) // RL11
    else $error("pointer not at first entry after restart");

  property p_io_reset;
    enable_r && rst_rise |=> ##1 cur_ptr_o == '0;
  endproperty
  a_io_reset: assert property (p_io_reset) // RL15
    else $error("input reset edge did not clear pointer");

  property p_acq_cmd;
    acq_i.multi_shot || acq_i.stream_start |=> ptr_r == '0;
  endproperty
  a_acq_cmd: assert property (p_acq_cmd) // RL19
    else $error("acquisition command did not reset pointer");

  property p_single;
    acq_i.single_shot |=> ptr_r == '0 && rep_r == 8'h00;
  endproperty
  a_single: assert property (p_single) // RL20
    else $error("single shot did not restart sequence");

  property p_hold_one;
    !restart && enable_r && step_req && hold_eff == 8'h01 && !at_last
      |=> ptr_r == $past(ptr_r) + PTR_W'(1);
  endproperty
  a_hold_one: assert property (p_hold_one) // RL8
    else $error("hold of one did not advance on each step");

  property p_hold_wait;
    !restart && enable_r && step_req && rep_r + 8'h01 < hold_eff
      |=> ptr_r == $past(ptr_r) && rep_r == $past(rep_r) + 8'h01;
  endproperty
  a_hold_wait: assert property (p_hold_wait) // RL7
    else $error("pointer moved before hold count reached");

  property p_last_stays;
    !restart && enable_r && at_last && !wrap_r |=> ptr_r == $past(ptr_r);
  endproperty
  a_last_stays: assert property (p_last_stays) // RL17
    else $error("pointer left last entry without wrap");

  property p_apply;
    enable_r && !preview_r && acq_i.expo_start
      |=> param_o == mem_param[$past(ptr_r)];
  endproperty
  a_apply: assert property (p_apply) // RL25
    else $error("exposure did not load entry at pointer");

  property p_expo_mode;
    enable_r && !preview_r && mode_expo && !restart && !acq_i.expo_start
      && !man_adv |=> ptr_r == $past(ptr_r);
  endproperty
  a_expo_mode: assert property (p_expo_mode) // RL3
    else $error("exposure-stepped entry moved without exposure");

  property p_edge_once;
    enable_r && !preview_r && mode_edge && step_rise && hold_eff == 8'h01
      && !at_last && !restart ##1 enable_r && !restart && !man_adv
      && !soft_io_step && !acq_i.expo_start
      |-> ptr_r == $past(ptr_r) + PTR_W'(1) ##1 ptr_r == $past(ptr_r);
  endproperty
  a_edge_once: assert property (p_edge_once) // RL14
    else $error("edge step did not move exactly once");

  property p_readback;
    bus_i.rd && bus_i.addr == OFS_STEP
      |=> rdata_o[STP_PTR_LSB +: PTR_W] == $past(ptr_r);
  endproperty
  a_readback: assert property (p_readback) // RL24
    else $error("pointer readback mismatch");

  property p_preview_hold;
    enable_r && preview_r && !restart |=> ptr_r == $past(ptr_r);
  endproperty
  a_preview_hold: assert property (p_preview_hold) // RL1
    else $error("pointer moved while preview active");

  property p_preview_out;
    enable_r && preview_r |=> preview_o;
  endproperty
  a_preview_out: assert property (p_preview_out) // RL1
    else $error("preview status not shown");

  property p_level_idle;
    enable_r && !preview_r && mode_level && !step_lvl && !soft_io_step
      && !man_adv && !restart |=> ptr_r == $past(ptr_r);
  endproperty
  a_level_idle: assert property (p_level_idle) // RL13
    else $error("level stepping moved with input low");

  property p_level_step;
    enable_r && !preview_r && mode_level && step_lvl && acq_i.expo_start
      && hold_eff == 8'h01 && !at_last && !restart
      |=> ptr_r == $past(ptr_r) + PTR_W'(1);
  endproperty
  a_level_step: assert property (p_level_step) // RL13
    else $error("high step level did not advance at exposure");

  property p_undef_src;
    enable_r && !preview_r && cur_src != SRC_EXPO && cur_src != SRC_EDGE
      && cur_src != SRC_LEVEL && acq_i.expo_start && hold_eff == 8'h01
      && !at_last && !restart |=> ptr_r == $past(ptr_r) + PTR_W'(1);
  endproperty
  a_undef_src: assert property (p_undef_src) // RL5
    else $error("undefined step source not treated as exposure");

  property p_manual;
    enable_r && !preview_r && man_adv && hold_eff == 8'h01 && !at_last
      && !restart |=> ptr_r == $past(ptr_r) + PTR_W'(1);
  endproperty
  a_manual: assert property (p_manual) // RL10
    else $error("manual advance did not step");

  property p_soft_reset;
    soft_io_rst |=> ptr_r == '0;
  endproperty
  a_soft_reset: assert property (p_soft_reset) // RL16
    else $error("software reset event did not clear pointer");

  property p_unload;
    wr_ctrl && enable_r && !bus_i.wdata[CTL_EN] |=> !loaded_r;
  endproperty
  a_unload: assert property (p_unload) // RL18
    else $error("stored sequence still marked loaded after stop");

  cover property (enable_r && advance && at_last && wrap_r);
  cover property (enable_r && mode_level && acq_i.expo_start && step_lvl);
  cover property (enable_r && mode_edge && step_rise);
  cover property (enable_r && preview_r ##1 !preview_r);

endmodule : ips_sequencer
`default_nettype wire

// [dv/ips_far_model.sv]
// Far-side model: external trigger lines and acquisition events
`timescale 1ns/1ps
`default_nettype none
module ips_far_model
  import ips_pkg::*;
(
  // Clock
  input wire logic mclk_i,
  // Driven toward the sequencer
  output logic [1:0] in_line_o,
  output ips_acq_t acq_o
);
  initial begin
    in_line_o = 2'h0;
    acq_o = '0;
  end

  // Lines are plain levels, changed only just after an edge
  task automatic set_line(input int idx, input logic val);
    @(posedge mclk_i);
    in_line_o[idx] <= val;
  endtask : set_line

  // One-cycle event: 0 exposure, 1 multi-shot, 2 stream start, 3 single
  task automatic pulse(input int kind);
    @(posedge mclk_i);
    acq_o <= ips_acq_t'(4'h8 >> kind);
    @(posedge mclk_i);
    acq_o <= '0;
  endtask : pulse
endmodule : ips_far_model
`default_nettype wire

// [dv/test_image_parameter_sequencer.sv]
// Testbench for the image parameter sequencer
`timescale 1ns/1ps
`default_nettype none
module test_image_parameter_sequencer;
  import ips_pkg::*;
  logic mclk_i = 1'b0;
  logic reset_i = 1'b1;
  ips_bus_t bus_i = '0;
  logic [31:0] rdata_o;
  ips_acq_t acq_i;
  logic [1:0] in_line_i;
  logic [15:0] param_o;
  logic [PTR_W-1:0] cur_ptr_o;
  logic preview_o;
  int fails = 0;
  int samples_checked = 0;
  logic [7:0] srcs [5] = '{SRC_EXPO, 8'h7F, SRC_EDGE, SRC_LEVEL, SRC_EXPO};
  logic [7:0] holds [5] = '{8'h02, 8'h00, 8'h01, 8'h01, 8'h01};

  always #20 mclk_i = ~mclk_i;

  ips_sequencer #(.PARAM_W(16)) DUT (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .bus_i(bus_i),
    .rdata_o(rdata_o),
    .acq_i(acq_i),
    .in_line_i(in_line_i),
    .param_o(param_o),
    .cur_ptr_o(cur_ptr_o),
    .preview_o(preview_o)
  );

  ips_far_model u_far (
    .mclk_i(mclk_i),
    .in_line_o(in_line_i),
    .acq_o(acq_i)
  );

  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    bus_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk_i);
    bus_i <= '0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk_i);
    bus_i <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge mclk_i);
    bus_i <= '0;
    #1 d = rdata_o;
  endtask : rd

  // Pointer output lags the internal pointer by one cycle
  task automatic ptr_is(input int p);
    repeat (3) @(posedge mclk_i);
    #1 chk(32'(cur_ptr_o), 32'(p));
  endtask : ptr_is

  task automatic expose(input int p, input logic [31:0] prm);
    u_far.pulse(0);
    ptr_is(p);
    chk(32'(param_o), prm);
  endtask : expose

  initial begin : main
    logic [31:0] d;
    repeat (8) @(posedge mclk_i);
    reset_i <= 1'b0;
    rd(OFS_CTRL, d);
    chk(32'(d[15:8]), 32'(RST_LEN));
    chk(32'(cur_ptr_o), 32'h0);
    for (int i = 0; i < 5; i++) begin
      wr(OFS_PARAM, {8'h00, holds[i], srcs[i], 8'(i)});
      wr(OFS_DATA, 32'hA000 + 32'(i));
    end
    rd(OFS_PARAM, d);
    chk(d, {8'h00, 8'h01, SRC_EXPO, 8'h04});
    wr(OFS_CTRL, 32'h0000_0501);
    expose(0, 32'hA000);
    expose(1, 32'hA000);
    expose(2, 32'hA001);
    expose(2, 32'hA002);
    wr(OFS_IOCFG, 32'h1);
    u_far.set_line(0, 1'b1);
    ptr_is(3);
    chk(32'(param_o), 32'hA002);
    expose(4, 32'hA003);
    expose(4, 32'hA004);
    rd(OFS_STEP, d);
    chk(32'(d[15:8]), 32'h4);
    wr(OFS_STEP, 32'h2);
    ptr_is(0);
    wr(OFS_STEP, 32'h1);
    ptr_is(0);
    wr(OFS_STEP, 32'h1);
    ptr_is(1);
    wr(OFS_STEP, 32'h1);
    u_far.set_line(0, 1'b0);
    ptr_is(2);
    wr(OFS_STEP, 32'h4);
    ptr_is(3);
    wr(OFS_STEP, 32'h8);
    ptr_is(0);
    repeat (3) wr(OFS_STEP, 32'h1);
    wr(OFS_IOCFG, 32'h5);
    u_far.set_line(0, 1'b1);
    ptr_is(2);
    u_far.set_line(1, 1'b1);
    ptr_is(3);
    u_far.set_line(0, 1'b0);
    u_far.set_line(1, 1'b0);
    wr(OFS_IOCFG, 32'h9);
    u_far.set_line(1, 1'b1);
    ptr_is(0);
    repeat (2) wr(OFS_STEP, 32'h1);
    ptr_is(1);
    u_far.set_line(1, 1'b0);
    wr(OFS_STEP, 32'h2);
    ptr_is(0);
    for (int k = 1; k < 4; k++) begin
      repeat (2) wr(OFS_STEP, 32'h1);
      ptr_is(1);
      u_far.pulse(k);
      ptr_is(0);
    end
    wr(OFS_PARAM, {8'h00, 8'h01, SRC_EXPO, 8'h03});
    wr(OFS_CTRL, 32'h0000_0503);
    expose(0, 32'hA003);
    chk(32'(preview_o), 32'h1);
    wr(OFS_CTRL, 32'h0000_0501);
    ptr_is(0);
    chk(32'(preview_o), 32'h0);
    wr(OFS_CTRL, 32'h0000_0000);
    rd(OFS_CTRL, d);
    chk(32'(d[3]), 32'h0);
    for (int i = 0; i < 2; i++) begin
      wr(OFS_PARAM, {8'h00, holds[i], srcs[i], 8'(i)});
      wr(OFS_DATA, 32'hA000 + 32'(i));
    end
    rd(OFS_CTRL, d);
    chk(32'(d[3]), 32'h1);
    // Wrap chosen before the stream starts
    wr(OFS_CTRL, 32'h0000_0205);
    u_far.pulse(2);
    expose(0, 32'hA000);
    expose(1, 32'hA000);
    wr(OFS_STEP, 32'h1);
    ptr_is(0);
    complete_run();
  end

  // Run needs well under a thousand cycles
  initial begin : watchdog
    #(40 * 20000);
    fails++;
    complete_run();
  end
endmodule : test_image_parameter_sequencer
`default_nettype wire
